// File: include/pim_pkg.sv
// Package: register map, field positions and reset values of the mask and measurement block
`default_nettype none
package pim_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_TOP_IRQ_MASK_A = 8'h20;
	localparam logic [7:0] ADDR_TOP_IRQ_MASK_B = 8'h21;
	localparam logic [7:0] ADDR_REGULATOR_IRQ_MASK = 8'h22;
	localparam logic [7:0] ADDR_LOAD_MEAS_SELECT = 8'h24;
	localparam logic [7:0] ADDR_LOAD_RESULT_HI = 8'h25;
	localparam logic [7:0] ADDR_LOAD_RESULT_LO = 8'h26;
	// Field positions in the first top mask register
	localparam int POS_PWR_GOOD = 7;
	localparam int POS_CLK_DET = 4;
	localparam int POS_HOT_DIE = 2;
	localparam int POS_MEAS_DONE = 0;
	// Field position in the second top mask register
	localparam int POS_REG_RESET = 0;
	// Field positions in the regulator mask register
	localparam int POS_B_PG_FALL = 7;
	localparam int POS_B_PG_RISE = 6;
	localparam int POS_B_OVERCURRENT = 4;
	localparam int POS_A_PG_FALL = 3;
	localparam int POS_A_PG_RISE = 2;
	localparam int POS_A_OVERCURRENT = 0;
	// Writable bits of each register
	localparam logic [7:0] WMASK_TOP_A = 8'hff;
	localparam logic [7:0] WMASK_REGULATOR = 8'hdd;
	localparam logic [7:0] WMASK_SELECT = 8'hff;
	// Reset values (mask fields default to all inhibited)
	localparam logic [7:0] RST_TOP_A = 8'h95;
	localparam logic [7:0] RST_TOP_B = 8'h01;
	localparam logic [7:0] RST_REGULATOR = 8'hdd;
	localparam logic [7:0] RST_SELECT = 8'h00;
	// Flag bit order in the event and flag vectors
	localparam int NUM_FLAGS = 9;
	localparam int FLG_PWR_GOOD = 0;
	localparam int FLG_CLK_DET = 1;
	localparam int FLG_HOT_DIE = 2;
	localparam int FLG_MEAS_DONE = 3;
	localparam int FLG_REG_RESET = 4;
	localparam int FLG_A_PG = 5;
	localparam int FLG_A_OVERCURRENT = 6;
	localparam int FLG_B_PG = 7;
	localparam int FLG_B_OVERCURRENT = 8;
	// Measurement result width and step
	localparam int LOAD_RESULT_W = 9;
	localparam int LOAD_STEP_MA = 20;
endpackage : pim_pkg
`default_nettype wire

// File: src/pim_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none
module pim_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] s1, s2, s3, held;
	logic [WIDTH-1:0] next_held;

	initial begin
		if (WIDTH < 1) $error("pim_sync3: WIDTH must be at least 1");
	end

	// Accept a bit once the two late stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_held[i] = (s2[i] == s3[i]) ? s3[i] : held[i];
		end
	end

	// Stage registers
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			held <= '0;
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
			held <= next_held;
		end
	end

	assign sync_o = held;
endmodule : pim_sync3
`default_nettype wire

// File: src/pim_edge_det.sv
// Edge detector for power-good raw levels, one-cycle rise and fall pulses
`default_nettype none
module pim_edge_det #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] level_i,
	output logic [WIDTH-1:0] rise_o,
	output logic [WIDTH-1:0] fall_o
);
	logic [WIDTH-1:0] last;
	logic [WIDTH-1:0] next_last;

	initial begin
		if (WIDTH < 1) $error("pim_edge_det: WIDTH must be at least 1");
	end

	// Remember the previous level
	always_comb begin
		next_last = level_i;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last <= '0;
		end else begin
			last <= next_last;
		end
	end

	// Level went 0->1 or 1->0
	assign rise_o = level_i & ~last;
	assign fall_o = ~level_i & last;
endmodule : pim_edge_det
`default_nettype wire

// File: src/pim_irq_ctrl.sv
// Interrupt masking, event flags and load-current measurement trigger
`default_nettype none
module pim_irq_ctrl (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// Register port from the serial interface
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Flag clear: write-one-to-clear vector
	input wire logic flag_clr_i,
	input wire logic [pim_pkg::NUM_FLAGS-1:0] flag_clr_bits_i,
	output logic [pim_pkg::NUM_FLAGS-1:0] flags_o,
	// OTP value of the register-reset mask
	input wire logic otp_reg_reset_inhibit_i,
	// Raw pins and analog levels (asynchronous)
	input wire logic pwr_good_pin_i,
	input wire logic clk_invalid_i,
	input wire logic hot_die_i,
	input wire logic reg_a_pg_invalid_i,
	input wire logic reg_b_pg_invalid_i,
	input wire logic reg_a_overcurrent_i,
	input wire logic reg_b_overcurrent_i,
	// Single-cycle events from same-clock logic
	input wire logic reg_reset_event_i,
	input wire logic meas_ready_i,
	input wire logic [pim_pkg::LOAD_RESULT_W-1:0] meas_result_i,
	// Measurement trigger toward the converter front end
	output logic meas_start_o,
	output logic meas_sel_o,
	// Live status outputs, unaffected by masks, then the masked interrupt line
	output logic pwr_good_live_flag_o,
	output logic clk_invalid_live_o,
	output logic hot_die_live_flag_o,
	output logic reg_a_pg_invalid_live_o,
	output logic reg_b_pg_invalid_live_o,
	output logic reg_a_overcurrent_live_o,
	output logic reg_b_overcurrent_live_o,
	output logic irq_n_o
);
	import pim_pkg::*;

	localparam int NRAW = 7;

	logic [7:0] top_irq_mask_a, top_irq_mask_b, regulator_irq_mask, load_meas_select;
	logic [7:0] next_top_irq_mask_a, next_top_irq_mask_b, next_regulator_irq_mask, next_load_meas_select;
	logic [NUM_FLAGS-1:0] flags, next_flags, events, enabled;
	logic [LOAD_RESULT_W-1:0] load_result, next_load_result;
	logic [7:0] rdata, next_rdata;
	logic meas_start, next_meas_start;
	logic irq_n, next_irq_n;
	logic [NRAW-1:0] raw_async, raw_sync, live, next_live;
	logic [1:0] pg_lvl, pg_rise, pg_fall;
	logic [NRAW-1:0] raw_last, next_raw_last;
	logic otp_load, next_otp_load;

	////////////////////////////////////////////////////////////////////////////
	// Elaboration checks

	// The read mux splits the result into one high bit and one low byte
	if (LOAD_RESULT_W != 9) begin : g_result_width_check
		$error("pim_irq_ctrl: load result width must be 9");
	end
	// Every flag index below must fit the flag vector
	if (NUM_FLAGS != 9) begin : g_flag_count_check
		$error("pim_irq_ctrl: flag count must be 9");
	end
	// Top mask field positions must lie inside an 8-bit register
	if (POS_PWR_GOOD > 7 || POS_CLK_DET > 7 || POS_HOT_DIE > 7 || POS_MEAS_DONE > 7
		|| POS_REG_RESET > 7) begin : g_top_pos_check
		$error("pim_irq_ctrl: top mask field position out of range");
	end
	// Regulator mask field positions must lie inside an 8-bit register
	if (POS_B_PG_FALL > 7 || POS_B_PG_RISE > 7 || POS_B_OVERCURRENT > 7 || POS_A_PG_FALL > 7
		|| POS_A_PG_RISE > 7 || POS_A_OVERCURRENT > 7) begin : g_reg_pos_check
		$error("pim_irq_ctrl: regulator mask field position out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisation and edges

	// Pack the raw levels
	// Raw bit order: 0 pwr good, 1 clock, 2 hot die, 3 A pg, 4 B pg, 5 A oc, 6 B oc
	assign raw_async = {reg_b_overcurrent_i, reg_a_overcurrent_i, reg_b_pg_invalid_i, reg_a_pg_invalid_i,
		hot_die_i, clk_invalid_i, pwr_good_pin_i};

	// Every raw level crosses here; nothing else samples the pins
	pim_sync3 #(.WIDTH(NRAW)) u_sync (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.async_i(raw_async),
		.sync_o(raw_sync)
	);

	// Regulator power-good levels: bit 0 is A, bit 1 is B (1 = invalid)
	assign pg_lvl = {raw_sync[4], raw_sync[3]};

	// A rise of the invalid level is a power-good fall, hence the crossed pins
	pim_edge_det #(.WIDTH(2)) u_pg_edge (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.level_i(pg_lvl),
		.rise_o(pg_fall),
		.fall_o(pg_rise)
	);

	// Event collection; pg "fall" means output went invalid
	always_comb begin
		events = '0;
		events[FLG_PWR_GOOD] = raw_sync[0] ^ raw_last[0];
		// Clock, thermal and overcurrent flags set on the rising level only
		events[FLG_CLK_DET] = raw_sync[1] & ~raw_last[1];
		events[FLG_HOT_DIE] = raw_sync[2] & ~raw_last[2];
		events[FLG_MEAS_DONE] = meas_ready_i;
		events[FLG_REG_RESET] = reg_reset_event_i;
		events[FLG_A_PG] = (pg_fall[0] & ~regulator_irq_mask[POS_A_PG_FALL])
			| (pg_rise[0] & ~regulator_irq_mask[POS_A_PG_RISE]);
		events[FLG_B_PG] = (pg_fall[1] & ~regulator_irq_mask[POS_B_PG_FALL])
			| (pg_rise[1] & ~regulator_irq_mask[POS_B_PG_RISE]);
		events[FLG_A_OVERCURRENT] = raw_sync[5] & ~raw_last[5];
		events[FLG_B_OVERCURRENT] = raw_sync[6] & ~raw_last[6];
		next_raw_last = raw_sync;
		next_live = raw_sync;
	end

	// Edge history and live status registers
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			live <= '0;
			raw_last <= '0;
		end else begin
			live <= next_live;
			raw_last <= next_raw_last;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mask enables per flag

	always_comb begin
		// Regulator power-good flags are gated at the edge, so they stay enabled here
		enabled = '1;
		enabled[FLG_PWR_GOOD] = ~top_irq_mask_a[POS_PWR_GOOD];
		enabled[FLG_CLK_DET] = ~top_irq_mask_a[POS_CLK_DET];
		enabled[FLG_HOT_DIE] = ~top_irq_mask_a[POS_HOT_DIE];
		enabled[FLG_MEAS_DONE] = ~top_irq_mask_a[POS_MEAS_DONE];
		enabled[FLG_REG_RESET] = ~top_irq_mask_b[POS_REG_RESET];
		enabled[FLG_B_OVERCURRENT] = ~regulator_irq_mask[POS_B_OVERCURRENT];
		enabled[FLG_A_OVERCURRENT] = ~regulator_irq_mask[POS_A_OVERCURRENT];
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes, flags and measurement trigger

	always_comb begin
		next_top_irq_mask_a = top_irq_mask_a;
		next_top_irq_mask_b = top_irq_mask_b;
		next_regulator_irq_mask = regulator_irq_mask;
		next_load_meas_select = load_meas_select;
		next_meas_start = 1'b0;
		next_otp_load = 1'b0;
		next_load_result = load_result;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				ADDR_TOP_IRQ_MASK_A: next_top_irq_mask_a = reg_wdata_i & WMASK_TOP_A;
				ADDR_TOP_IRQ_MASK_B: next_top_irq_mask_b = top_irq_mask_b;
				ADDR_REGULATOR_IRQ_MASK: next_regulator_irq_mask = reg_wdata_i & WMASK_REGULATOR;
				ADDR_LOAD_MEAS_SELECT: begin
					next_load_meas_select = reg_wdata_i & WMASK_SELECT;
					next_meas_start = 1'b1;
				end
				// Result registers and unmapped offsets ignore writes
				default: ;
			endcase
		end
		// Applied after the decode above, so the OTP copy beats any host write
		// OTP load after reset
		if (otp_load) begin
			next_top_irq_mask_b = {RST_TOP_B[7:1], otp_reg_reset_inhibit_i};
		end
		if (meas_ready_i) begin
			next_load_result = meas_result_i;
		end
		// An event landing with its clear is kept, so none is lost
		// set wins over clear
		next_flags = flags;
		if (flag_clr_i) begin
			next_flags = next_flags & ~flag_clr_bits_i;
		end
		next_flags = next_flags | events;
		// Built from the next flags so the line moves with flags_o
		// interrupt level
		next_irq_n = ~|(next_flags & enabled);
	end

	// Read mux
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_TOP_IRQ_MASK_A: next_rdata = top_irq_mask_a;
				ADDR_TOP_IRQ_MASK_B: next_rdata = top_irq_mask_b;
				ADDR_REGULATOR_IRQ_MASK: next_rdata = regulator_irq_mask;
				ADDR_LOAD_MEAS_SELECT: next_rdata = load_meas_select;
				ADDR_LOAD_RESULT_HI: next_rdata = {7'h00, load_result[8]};
				ADDR_LOAD_RESULT_LO: next_rdata = load_result[7:0];
				default: next_rdata = 8'h00;
			endcase
		end else begin
			next_rdata = rdata;
		end
	end

	// Read data register, holding the last answer until the next read
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// Mask, flag and trigger registers
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			top_irq_mask_a <= RST_TOP_A;
			top_irq_mask_b <= RST_TOP_B;
			regulator_irq_mask <= RST_REGULATOR;
			load_meas_select <= RST_SELECT;
			flags <= '0;
			load_result <= '0;
			meas_start <= 1'b0;
			irq_n <= 1'b1;
			otp_load <= 1'b1;
		end else begin
			top_irq_mask_a <= next_top_irq_mask_a;
			top_irq_mask_b <= next_top_irq_mask_b;
			regulator_irq_mask <= next_regulator_irq_mask;
			load_meas_select <= next_load_meas_select;
			flags <= next_flags;
			load_result <= next_load_result;
			meas_start <= next_meas_start;
			irq_n <= next_irq_n;
			otp_load <= next_otp_load;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops

	assign reg_rdata_o = rdata;
	assign flags_o = flags;
	assign meas_start_o = meas_start;
	assign meas_sel_o = load_meas_select[0];
	assign irq_n_o = irq_n;
	// Live copies trail the synchroniser by one cycle; masks never touch them
	assign pwr_good_live_flag_o = live[0];
	assign clk_invalid_live_o = live[1];
	assign hot_die_live_flag_o = live[2];
	assign reg_a_pg_invalid_live_o = live[3];
	assign reg_b_pg_invalid_live_o = live[4];
	assign reg_a_overcurrent_live_o = live[5];
	assign reg_b_overcurrent_live_o = live[6];
endmodule : pim_irq_ctrl
`default_nettype wire

// File: sim/pim_irq_ctrl_properties.sv
// Port-level checks on the mask and measurement block
`default_nettype none
module pim_irq_ctrl_properties (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic flag_clr_i,
	input wire logic [pim_pkg::NUM_FLAGS-1:0] flag_clr_bits_i,
	input wire logic [pim_pkg::NUM_FLAGS-1:0] flags_o,
	input wire logic otp_reg_reset_inhibit_i,
	input wire logic pwr_good_pin_i,
	input wire logic reg_b_overcurrent_i,
	input wire logic meas_ready_i,
	input wire logic meas_start_o,
	input wire logic meas_sel_o,
	input wire logic pwr_good_live_flag_o,
	input wire logic reg_b_overcurrent_live_o,
	input wire logic irq_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import pim_pkg::*;
	logic sel_wr;
	// Write to the select register
	assign sel_wr = reg_wr_i && reg_addr_i == ADDR_LOAD_MEAS_SELECT;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	AST_START: assert property (sel_wr |=> meas_start_o ##1 !meas_start_o) else $error("start pulse wrong");
	AST_NOSTART: assert property (meas_start_o |-> $past(sel_wr)) else $error("start without write");
	AST_SEL: assert property (sel_wr |=> meas_sel_o == $past(reg_wdata_i[0])) else $error("select wrong");
	AST_MEAS: assert property (meas_ready_i |=> flags_o[FLG_MEAS_DONE]) else $error("ready flag not set");
	AST_CLR: assert property (flag_clr_i && flag_clr_bits_i[FLG_MEAS_DONE] && !meas_ready_i
		|=> !flags_o[FLG_MEAS_DONE]) else $error("flag not cleared");
	AST_IRQ: assert property (flags_o == '0 |-> irq_n_o) else $error("interrupt without flag");
	AST_RSVD: assert property (reg_rd_i && reg_addr_i == ADDR_REGULATOR_IRQ_MASK
		|=> (reg_rdata_o & 8'h22) == 8'h00) else $error("reserved bits set");
	AST_OTP: assert property (reg_rd_i && reg_addr_i == ADDR_TOP_IRQ_MASK_B
		|=> reg_rdata_o[0] == otp_reg_reset_inhibit_i) else $error("otp bit lost");
	AST_LIVE: assert property (pwr_good_pin_i [*6] |-> pwr_good_live_flag_o) else $error("live level stale");
	AST_OCLIVE: assert property (!reg_b_overcurrent_i [*6] |-> !reg_b_overcurrent_live_o) else $error("live stale");
	// Main scenarios reached
	cover property (sel_wr);
	cover property ($fell(irq_n_o));
	cover property (flag_clr_i && flags_o != '0);
endmodule : pim_irq_ctrl_properties
bind pim_irq_ctrl pim_irq_ctrl_properties i_props (.ref_clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
	.reg_wdata_i, .reg_rdata_o, .flag_clr_i, .flag_clr_bits_i, .flags_o, .otp_reg_reset_inhibit_i, .pwr_good_pin_i,
	.reg_b_overcurrent_i, .meas_ready_i, .meas_start_o, .meas_sel_o, .pwr_good_live_flag_o, .reg_b_overcurrent_live_o,
	.irq_n_o);
`default_nettype wire

// File: sim/pim_host_model.sv
// Host model: register reads, writes and flag clears
`default_nettype none
module pim_host_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic clr_o,
	output logic [8:0] clr_bits_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		{wr_o, rd_o, clr_o, addr_o, wdata_o, clr_bits_o} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge ref_clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr
	// Read, data taken once registered
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge ref_clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge ref_clk_i);
		#1 d = rdata_i;
	endtask : rd
	task automatic clr(input logic [8:0] b);
		@(posedge ref_clk_i);
		clr_o <= 1'b1;
		clr_bits_o <= b;
		@(posedge ref_clk_i);
		clr_o <= 1'b0;
		clr_bits_o <= '0;
	endtask : clr
endmodule : pim_host_model
`default_nettype wire

// File: sim/pim_irq_ctrl_tb.sv
// Self-checking bench for the mask and measurement block
`default_nettype none
module pim_irq_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pim_pkg::*;
	logic ref_clk = 1'b0, resetn = 1'b0, wr, rd, clr, rdy = 1'b0, rst_ev = 1'b0, start, sel, irq_n;
	logic [7:0] addr, wdata, rdata, d, q;
	logic [8:0] cbits, flags, res = '0;
	logic [6:0] pins = '0, lives;
	int failures = 0, check_count = 0;
	logic [7:0] ra[5] = '{8'h20, 8'h21, 8'h22, 8'h24, 8'h30};
	logic [7:0] re[5] = '{RST_TOP_A, RST_TOP_B | 8'h01, RST_REGULATOR, RST_SELECT, 8'h00};
	int ep[9] = '{0, 1, 2, 3, 3, 4, 4, 5, 6};
	int eb[9] = '{7, 4, 2, 3, 2, 7, 6, 0, 4};
	int ef[9] = '{0, 1, 2, 5, 5, 7, 7, 6, 8};
	logic el[9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	pim_host_model i_host (.ref_clk_i(ref_clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr),
		.wdata_o(wdata), .clr_o(clr), .clr_bits_o(cbits));
	pim_irq_ctrl i_dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .flag_clr_i(clr), .flag_clr_bits_i(cbits), .flags_o(flags),
		.otp_reg_reset_inhibit_i(1'b1), .pwr_good_pin_i(pins[0]), .clk_invalid_i(pins[1]), .hot_die_i(pins[2]),
		.reg_a_pg_invalid_i(pins[3]), .reg_b_pg_invalid_i(pins[4]), .reg_a_overcurrent_i(pins[5]),
		.reg_b_overcurrent_i(pins[6]), .reg_reset_event_i(rst_ev), .meas_ready_i(rdy), .meas_result_i(res),
		.meas_start_o(start), .meas_sel_o(sel), .pwr_good_live_flag_o(lives[0]), .clk_invalid_live_o(lives[1]),
		.hot_die_live_flag_o(lives[2]), .reg_a_pg_invalid_live_o(lives[3]), .reg_b_pg_invalid_live_o(lives[4]),
		.reg_a_overcurrent_live_o(lives[5]), .reg_b_overcurrent_live_o(lives[6]), .irq_n_o(irq_n));
	// Clock, 20 ns period
	always #10 ref_clk = ~ref_clk;
	// Mask register value with one bit open or all inhibited
	function automatic logic [7:0] mask_val(input int b, input logic m);
		return m ? 8'hff : ~(8'h01 << b);
	endfunction : mask_val
	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Report and end the run
	task automatic conclude();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	// Clear every flag and see the line released
	task automatic clear_all();
		i_host.clr(9'h1ff);
		repeat (2) @(posedge ref_clk);
		#1 check(flags, 9'h000);
		check(irq_n, 1'b1);
	endtask : clear_all
	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		conclude();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h6652));
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		// Reset values, unmapped read, refused writes
		foreach (ra[i]) begin
			i_host.rd(ra[i], q);
			check(q, re[i]);
		end
		repeat (4) begin
			d = 8'($urandom);
			i_host.wr(ADDR_REGULATOR_IRQ_MASK, d);
			i_host.rd(ADDR_REGULATOR_IRQ_MASK, q);
			check(q, d & WMASK_REGULATOR);
			i_host.wr(ADDR_TOP_IRQ_MASK_B, d);
			i_host.rd(ADDR_TOP_IRQ_MASK_B, q);
			check(q, RST_TOP_B | 8'h01);
		end
		// Measurement start, result and ready interrupt
		for (int s = 0; s < 2; s++) begin
			i_host.wr(ADDR_LOAD_MEAS_SELECT, {7'($urandom), s[0]});
			#1 check(start, 1'b1);
			check(sel, s[0]);
			i_host.wr(ADDR_TOP_IRQ_MASK_A, mask_val(POS_MEAS_DONE, s[0]));
			@(posedge ref_clk);
			rdy <= 1'b1;
			res <= 9'($urandom);
			@(posedge ref_clk);
			rdy <= 1'b0;
			@(posedge ref_clk);
			#1 check(flags[FLG_MEAS_DONE], 1'b1);
			check(irq_n, s[0]);
			i_host.rd(ADDR_LOAD_RESULT_HI, q);
			check(q, {7'h00, res[8]});
			i_host.rd(ADDR_LOAD_RESULT_LO, q);
			check(q, res[7:0]);
			clear_all();
		end
		// Register reset event stays masked by the OTP bit
		@(posedge ref_clk);
		rst_ev <= 1'b1;
		@(posedge ref_clk);
		rst_ev <= 1'b0;
		@(posedge ref_clk);
		#1 check(flags[FLG_REG_RESET], 1'b1);
		check(irq_n, 1'b1);
		clear_all();
		// Each source inhibited then open: live level, flag, interrupt line
		for (int e = 0; e < 9; e++) begin
			for (int m = 1; m >= 0; m--) begin
				i_host.wr(ADDR_TOP_IRQ_MASK_A, e < 3 ? mask_val(eb[e], m[0]) : 8'hff);
				i_host.wr(ADDR_REGULATOR_IRQ_MASK, e < 3 ? 8'hff : mask_val(eb[e], m[0]));
				@(posedge ref_clk);
				pins[ep[e]] <= !el[e];
				repeat (8) @(posedge ref_clk);
				clear_all();
				@(posedge ref_clk);
				pins[ep[e]] <= el[e];
				repeat (8) @(posedge ref_clk);
				#1 check(lives[ep[e]], el[e]);
				check(irq_n, m[0]);
				if (m == 0) check(flags[ef[e]], 1'b1);
			end
			@(posedge ref_clk);
			pins <= '0;
			repeat (8) @(posedge ref_clk);
		end
		conclude();
	end
endmodule : pim_irq_ctrl_tb
`default_nettype wire
